// ===== serial_one_port.sv
// Second serial port: control register, four framing modes, receive buffer.
// Assumes a CPU on the plain register port and a remote partner on the pins;
// baud_tick is a one-cycle pulse at sixteen times the variable bit rate.
`timescale 1ns/1ps
module serial_one_port
    import serial_one_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic baud_tick,
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe,
    output logic clock_pin_out,
    output logic irq
);

    function automatic mode_t decode_mode(input logic hi, input logic lo);
        case ({hi, lo})
            2'h0: return MODE_SHIFT;
            2'h1: return MODE_ASYNC10;
            2'h2: return MODE_FIXED11;
            default: return MODE_VAR11;
        endcase
    endfunction

    logic [7:0] interrupt_enable_bits;
    logic frame_mode_hi, frame_mode_lo, multiproc_filter, receive_allow;
    logic tx_ninth_bit, rx_ninth_bit, transmit_done_flag, receive_done_flag;
    logic frame_error_flag, double_rate, serial_framing_select;
    logic data_meta, data_sync, data_prev;
    logic [1:0] fixed_div;
    logic [3:0] shift_cnt;
    logic tx_busy, tx_shift_mode;
    logic [3:0] tx_phase, tx_bits_left;
    logic [10:0] tx_shift;
    rx_state_t rx_state, next_rx_state;
    logic [3:0] rx_phase, rx_bits_left;
    logic [9:0] rx_shift;
    rx_word_t pend_word;
    rx_word_t fifo_mem [2];
    logic fifo_wr_ptr, fifo_rd_ptr;
    logic [1:0] fifo_count;

    // Register decode.
    wire wr_ie = wr_en && addr == IE_OFFSET;
    wire wr_scon = wr_en && addr == SCON_OFFSET;
    wire wr_pwr = wr_en && addr == PWR_OFFSET;
    wire wr_buf = wr_en && addr == DATA_OFFSET;
    wire rd_buf = rd_en && addr == DATA_OFFSET;

    mode_t mode;
    assign mode = decode_mode(frame_mode_hi, frame_mode_lo);
    wire is_shift = mode == MODE_SHIFT;
    wire is_nine = mode == MODE_FIXED11 || mode == MODE_VAR11;

    // Oversample tick: fixed divider in mode 2, outside baud source otherwise.
    wire [1:0] fixed_last = double_rate ? FIXED_FAST_LAST : FIXED_SLOW_LAST;
    wire fixed_tick = fixed_div == fixed_last;
    wire async_tick = (mode == MODE_FIXED11) ? fixed_tick : baud_tick;

    // Mode 0 shift clock, running only while a mode 0 transfer is active.
    wire shift_active = (tx_busy && tx_shift_mode) || rx_state == RX_SHIFT0;
    wire [3:0] shift_last = multiproc_filter ? SHIFT_FAST_LAST : SHIFT_SLOW_LAST;
    wire [3:0] shift_half = multiproc_filter ? SHIFT_FAST_HALF : SHIFT_SLOW_HALF;
    wire shift_end = shift_active && shift_cnt == shift_last;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fixed_div <= 2'h0;
            shift_cnt <= 4'h0;
        end else begin
            fixed_div <= fixed_tick ? 2'h0 : fixed_div + 2'h1;
            shift_cnt <= (!shift_active || shift_end) ? 4'h0 : shift_cnt + 4'h1;
        end
    end

    // Transmitter.
    wire tx_start = wr_buf && !tx_busy && rx_state != RX_SHIFT0;
    wire tx_bit_end = tx_busy
        && (tx_shift_mode ? shift_end : (async_tick && tx_phase == PHASE_LAST));
    // Mode 0 flags at the end of the eighth bit, async modes as the stop bit begins.
    wire ti_set = tx_bit_end
        && (tx_shift_mode ? tx_bits_left == 4'h1 : tx_bits_left == 4'h2);
    wire [3:0] tx_len = is_shift ? SHIFT_BITS : (is_nine ? ELEVEN_BITS : TEN_BITS);
    // Unused upper positions are stop level so a shorter frame idles high.
    wire [10:0] tx_load = is_shift ? {3'h7, wr_data}
        : {1'b1, is_nine ? tx_ninth_bit : 1'b1, wr_data, 1'b0};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_busy <= 1'b0;
            tx_shift_mode <= 1'b0;
            tx_phase <= 4'h0;
            tx_bits_left <= 4'h0;
            tx_shift <= 11'h7ff;
        end else if (tx_start) begin
            tx_busy <= 1'b1;
            tx_shift_mode <= is_shift;
            tx_phase <= 4'h0;
            tx_bits_left <= tx_len;
            tx_shift <= tx_load;
        end else begin
            tx_phase <= async_tick ? tx_phase + 4'h1 : tx_phase;
            if (tx_bit_end) begin
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_bits_left <= tx_bits_left - 4'h1;
                tx_busy <= tx_bits_left != 4'h1;
            end
        end
    end

    // Pin synchroniser; only data_sync and later stages feed logic.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_meta <= 1'b1;
            data_sync <= 1'b1;
            data_prev <= 1'b1;
        end else begin
            data_meta <= data_pin_in;
            data_sync <= data_meta;
            data_prev <= data_sync;
        end
    end

    // Receiver.
    wire rx_sample = async_tick && rx_phase == PHASE_MID;
    wire [9:0] frame_full = {data_sync, rx_shift[9:1]};
    wire rx_bit = (rx_state == RX_DATA && rx_sample) || (rx_state == RX_SHIFT0 && shift_end);
    wire rx_last = rx_bit && rx_bits_left == 4'h1;
    wire stop_ok = frame_full[9];
    rx_word_t new_word;
    assign new_word.data = is_shift ? frame_full[9:2] : (is_nine ? frame_full[7:0] : frame_full[8:1]);
    assign new_word.ninth = is_nine ? frame_full[8] : frame_full[9];
    wire accept = is_shift || !multiproc_filter
        || (is_nine ? frame_full[8] : stop_ok);
    wire fe_set = rx_last && !is_shift && !stop_ok;
    wire fifo_ready = fifo_count != 2'h2;
    wire fifo_valid = fifo_count != 2'h0;
    wire push_valid = (rx_last && accept) || rx_state == RX_HOLD;
    rx_word_t push_word;
    assign push_word = (rx_state == RX_HOLD) ? pend_word : new_word;
    wire push = push_valid && fifo_ready;
    wire pop = rd_buf && fifo_valid;
    wire ri_set = push;
    wire rx9_set = push && !is_shift && (is_nine || !multiproc_filter);

    // A mode 0 receive restarts only once the receive flag is clear, so software paces it.
    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            RX_IDLE: begin
                if (receive_allow && is_shift && !receive_done_flag && !tx_busy) begin
                    next_rx_state = RX_SHIFT0;
                end else if (receive_allow && !is_shift && data_prev && !data_sync) begin
                    next_rx_state = RX_START;
                end
            end
            RX_START: begin
                if (!receive_allow) begin
                    next_rx_state = RX_IDLE;
                end else if (rx_sample) begin
                    next_rx_state = data_sync ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA, RX_SHIFT0: begin
                if (!receive_allow) begin
                    next_rx_state = RX_IDLE;
                end else if (rx_last) begin
                    next_rx_state = (accept && !fifo_ready) ? RX_HOLD : RX_IDLE;
                end
            end
            RX_HOLD: begin
                if (fifo_ready) begin
                    next_rx_state = RX_IDLE;
                end
            end
            default: next_rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state <= RX_IDLE;
            rx_phase <= 4'h0;
            rx_bits_left <= 4'h0;
            rx_shift <= 10'h000;
            pend_word <= '0;
        end else begin
            rx_state <= next_rx_state;
            if (rx_state == RX_IDLE) begin
                rx_phase <= 4'h0;
                rx_bits_left <= is_shift ? SHIFT_BITS : (is_nine ? ELEVEN_SAMPLES : TEN_SAMPLES);
            end else begin
                rx_phase <= async_tick ? rx_phase + 4'h1 : rx_phase;
            end
            if (rx_bit) begin
                rx_shift <= frame_full;
                rx_bits_left <= rx_bits_left - 4'h1;
            end
            if (rx_last) begin
                pend_word <= new_word;
            end
        end
    end

    // Two-entry receive buffer; a full buffer stalls the receiver in RX_HOLD,
    // so a slow reader costs only the next frame's start, never a word.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo_wr_ptr <= 1'b0;
            fifo_rd_ptr <= 1'b0;
            fifo_count <= 2'h0;
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
        end else begin
            if (push) begin
                fifo_mem[fifo_wr_ptr] <= push_word;
                fifo_wr_ptr <= !fifo_wr_ptr;
            end
            if (pop) begin
                fifo_rd_ptr <= !fifo_rd_ptr;
            end
            fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Control registers; a hardware set wins over a software clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interrupt_enable_bits <= IE_RESET;
            {double_rate, serial_framing_select} <= PWR_RESET[7:6];
            {frame_mode_hi, frame_mode_lo, multiproc_filter, receive_allow} <= SCON_RESET[7:4];
            {tx_ninth_bit, rx_ninth_bit, transmit_done_flag, receive_done_flag} <= SCON_RESET[3:0];
            frame_error_flag <= 1'b0;
        end else begin
            if (wr_ie) begin
                interrupt_enable_bits <= wr_data;
            end
            if (wr_pwr) begin
                double_rate <= wr_data[BIT_DOUBLE_RATE];
                serial_framing_select <= wr_data[BIT_FRAMING_SEL];
            end
            if (wr_scon) begin
                frame_mode_lo <= wr_data[BIT_MODE_LO];
                multiproc_filter <= wr_data[BIT_FILTER];
                receive_allow <= wr_data[BIT_RX_ALLOW];
                tx_ninth_bit <= wr_data[BIT_TX_NINTH];
            end
            if (wr_scon && !serial_framing_select) begin
                frame_mode_hi <= wr_data[BIT_MODE_HI];
            end
            frame_error_flag <= fe_set
                | ((wr_scon && serial_framing_select) ? wr_data[BIT_MODE_HI] : frame_error_flag);
            rx_ninth_bit <= rx9_set ? push_word.ninth
                : (wr_scon ? wr_data[BIT_RX_NINTH] : rx_ninth_bit);
            transmit_done_flag <= ti_set
                | (wr_scon ? wr_data[BIT_TX_DONE] : transmit_done_flag);
            receive_done_flag <= ri_set
                | (wr_scon ? wr_data[BIT_RX_DONE] : receive_done_flag);
        end
    end

    // Read path.
    wire bit7_view = serial_framing_select ? frame_error_flag : frame_mode_hi;
    wire [7:0] scon_view = {bit7_view, frame_mode_lo, multiproc_filter, receive_allow,
        tx_ninth_bit, rx_ninth_bit, transmit_done_flag, receive_done_flag};
    wire [7:0] buf_view = fifo_valid ? fifo_mem[fifo_rd_ptr].data : 8'h00;
    wire [7:0] read_value = (addr == IE_OFFSET) ? interrupt_enable_bits
        : (addr == SCON_OFFSET) ? scon_view
        : (addr == PWR_OFFSET) ? {double_rate, serial_framing_select, 6'h00}
        : (addr == DATA_OFFSET) ? buf_view : 8'h00;

    // The power-fail source lives outside this port, so the gate masks all here.
    wire next_irq = interrupt_enable_bits[BIT_GLOBAL_GATE]
        && interrupt_enable_bits[BIT_SERIAL1_EN]
        && (transmit_done_flag || receive_done_flag);

    // Pins: in mode 0 the data pin is two-way and the clock pin carries the shift clock.
    wire next_clock_pin = shift_active ? (shift_cnt >= shift_half)
        : (tx_busy ? tx_shift[0] : 1'b1);
    wire next_data_oe = tx_busy && tx_shift_mode;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
            irq <= 1'b0;
            clock_pin_out <= 1'b1;
            data_pin_out <= 1'b1;
            data_pin_oe <= 1'b0;
        end else begin
            rd_data <= rd_en ? read_value : 8'h00;
            irq <= next_irq;
            clock_pin_out <= next_clock_pin;
            data_pin_out <= next_data_oe ? tx_shift[0] : 1'b1;
            data_pin_oe <= next_data_oe;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_control_bit_view: assert property (
        rd_en && addr == SCON_OFFSET |=> rd_data[7] == $past(bit7_view))
        else $error("control bit 7 read shows the wrong field");
    chk_frame_error_sticky: assert property (
        frame_error_flag && !(wr_scon && serial_framing_select) |=> frame_error_flag)
        else $error("framing error cleared without a software write");
    chk_shift_fast_period: assert property (
        shift_end && tx_busy && tx_bits_left > 4'h1 && multiproc_filter && !wr_scon
        |=> !shift_end [*3] ##1 shift_end)
        else $error("fast mode 0 bit is not four clocks");
    chk_tx_done_stop: assert property (
        $rose(transmit_done_flag) && !tx_shift_mode && !$past(wr_scon)
        |-> tx_bits_left == 4'h1 && tx_shift[0])
        else $error("transmit flag not set at the stop bit");
    chk_filter_nine: assert property (
        ri_set && rx_state != RX_HOLD && is_nine && multiproc_filter |-> push_word.ninth)
        else $error("receive flag set for ninth bit zero");
    chk_filter_stop: assert property (
        ri_set && rx_state != RX_HOLD && mode == MODE_ASYNC10 && multiproc_filter
        |-> push_word.ninth)
        else $error("receive flag set without a valid stop bit");
    chk_rx_disallowed: assert property (
        !receive_allow && rx_state == RX_IDLE |=> rx_state == RX_IDLE)
        else $error("reception started while disabled");
    chk_irq_gating: assert property (
        !interrupt_enable_bits[BIT_GLOBAL_GATE] |=> !irq)
        else $error("interrupt raised with global gate closed");
    chk_irq_raise: assert property (
        $rose(receive_done_flag) && interrupt_enable_bits[BIT_GLOBAL_GATE]
        && interrupt_enable_bits[BIT_SERIAL1_EN] && !wr_ie |=> irq)
        else $error("interrupt not raised on receive flag");
    chk_frame_length: assert property (
        tx_start && is_nine |=> tx_bits_left == ELEVEN_BITS)
        else $error("eleven-bit frame loaded with wrong length");
    chk_ten_bit_frame: assert property (
        tx_start && mode == MODE_ASYNC10 |=> tx_bits_left == TEN_BITS)
        else $error("ten-bit frame loaded with wrong length");
    chk_ninth_shift_idle: assert property (
        is_shift && !wr_scon |=> $stable(rx_ninth_bit))
        else $error("received ninth bit changed in mode 0");

    cov_shift_transfer: cover property (ti_set && tx_shift_mode);
    cov_async_receive: cover property (ri_set && !is_shift);
    cov_receiver_stall: cover property (rx_state == RX_HOLD ##1 rx_state == RX_IDLE);
    cov_shift_receive: cover property (ri_set && is_shift);

endmodule // serial_one_port

// ===== serial_one_pkg.sv
// Constants, types and register map of the second serial port.
// Assumes one 25 MHz clock that is also the oscillator clock of the port.
package serial_one_pkg;

    // Register byte offsets on the plain register port.
    localparam logic [7:0] IE_OFFSET = 8'ha8;
    localparam logic [7:0] SCON_OFFSET = 8'hc0;
    localparam logic [7:0] DATA_OFFSET = 8'hc1;
    localparam logic [7:0] PWR_OFFSET = 8'h87;

    // Field positions in the serial control register.
    localparam int BIT_MODE_HI = 7;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_FILTER = 5;
    localparam int BIT_RX_ALLOW = 4;
    localparam int BIT_TX_NINTH = 3;
    localparam int BIT_RX_NINTH = 2;
    localparam int BIT_TX_DONE = 1;
    localparam int BIT_RX_DONE = 0;
    // Field positions in the interrupt enable and power control registers.
    localparam int BIT_GLOBAL_GATE = 7;
    localparam int BIT_SERIAL1_EN = 6;
    localparam int BIT_DOUBLE_RATE = 7;
    localparam int BIT_FRAMING_SEL = 6;

    localparam logic [7:0] IE_RESET = 8'h00;
    localparam logic [7:0] SCON_RESET = 8'h00;
    localparam logic [7:0] PWR_RESET = 8'h00;

    // Bit timing in oscillator clocks.
    localparam int SHIFT_CLKS_SLOW = 12;
    localparam int SHIFT_CLKS_FAST = 4;
    localparam int FIXED_CLKS_SLOW = 64;
    localparam int FIXED_CLKS_FAST = 32;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] SHIFT_SLOW_LAST = 4'(SHIFT_CLKS_SLOW - 1);
    localparam logic [3:0] SHIFT_FAST_LAST = 4'(SHIFT_CLKS_FAST - 1);
    localparam logic [3:0] SHIFT_SLOW_HALF = 4'(SHIFT_CLKS_SLOW / 2);
    localparam logic [3:0] SHIFT_FAST_HALF = 4'(SHIFT_CLKS_FAST / 2);
    localparam logic [1:0] FIXED_SLOW_LAST = 2'(FIXED_CLKS_SLOW / OVERSAMPLE - 1);
    localparam logic [1:0] FIXED_FAST_LAST = 2'(FIXED_CLKS_FAST / OVERSAMPLE - 1);
    localparam logic [3:0] PHASE_MID = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [3:0] PHASE_LAST = 4'(OVERSAMPLE - 1);

    // Frame lengths in bits, and bits sampled after the start bit.
    localparam logic [3:0] SHIFT_BITS = 4'h8;
    localparam logic [3:0] TEN_BITS = 4'ha;
    localparam logic [3:0] ELEVEN_BITS = 4'hb;
    localparam logic [3:0] TEN_SAMPLES = 4'h9;
    localparam logic [3:0] ELEVEN_SAMPLES = 4'ha;

    typedef enum logic [1:0] {MODE_SHIFT, MODE_ASYNC10, MODE_FIXED11, MODE_VAR11} mode_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_SHIFT0, RX_HOLD} rx_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
    } rx_word_t;

endpackage

// ===== serial_partner.sv
// Remote serial partner that stands on the link pins of the second serial port.
// Assumes the bench calls its tasks; bit times are counted in cycles of clk.
`timescale 1ns/1ps
module serial_partner (
    input wire logic clk,
    input wire logic line_in,
    input wire logic shift_data,
    input wire logic shift_oe,
    output logic drive_line
);
    // The link has a pull-up, so the line rests high whenever nobody sends.
    initial drive_line = 1'b1;

    task automatic send_frame(input logic [7:0] d, input logic nine, input logic use_nine,
                              input logic stop, input int cpb);
        logic [10:0] bits;
        int n;
        bits = use_nine ? {stop, nine, d, 1'b0} : {1'b1, stop, d, 1'b0};
        n = use_nine ? 11 : 10;
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            drive_line <= bits[i];
            repeat (cpb) @(posedge clk);
        end
        drive_line <= 1'b1;
    endtask

    // Samples every bit in its middle, the way a real receiver would.
    task automatic recv_frame(input int cpb, input logic use_nine, output logic [7:0] d,
                              output logic nine, output logic stop, output logic ok);
        logic [9:0] got;
        int w;
        int n;
        w = 0;
        ok = 1'b0;
        n = use_nine ? 10 : 9;
        while (line_in !== 1'b0 && w < 4000) begin
            @(posedge clk);
            w++;
        end
        repeat (cpb / 2) @(posedge clk);
        ok = (w < 4000) && (line_in === 1'b0);
        for (int i = 0; i < n; i++) begin
            repeat (cpb) @(posedge clk);
            got[i] = line_in;
        end
        d = got[7:0];
        nine = use_nine ? got[8] : 1'b0;
        stop = got[n - 1];
    endtask

    // Shift mode: data is taken at each rising edge of the shift clock.
    task automatic recv_shift(output logic [7:0] d, output int period, output logic ok);
        logic prev;
        int k;
        int t0;
        k = 0;
        t0 = 0;
        prev = 1'b1;
        period = 0;
        for (int t = 0; t < 300 && k < 8; t++) begin
            @(posedge clk);
            if (prev === 1'b0 && line_in === 1'b1 && shift_oe === 1'b1) begin
                d[k] = shift_data;
                if (k == 1) period = t - t0;
                t0 = t;
                k++;
            end
            prev = line_in;
        end
        ok = (k == 8);
    endtask

    // Shift mode receive: the port clocks the line; each new bit follows a falling edge.
    task automatic send_shift(input logic [7:0] d, output logic ok);
        logic prev;
        int k;
        k = 0;
        prev = 1'b1;
        drive_line <= d[0];
        for (int t = 0; t < 300 && k < 8; t++) begin
            @(posedge clk);
            if (prev === 1'b1 && line_in === 1'b0) begin
                if (k > 0) drive_line <= d[k];
                k++;
            end
            prev = line_in;
        end
        repeat (16) @(posedge clk);
        drive_line <= 1'b1;
        ok = (k == 8);
    endtask
endmodule // serial_partner

// ===== tb_second_serial_port.sv
// Self-checking bench for the second serial port with a remote partner on the pins.
// Assumes one 25 MHz clock; the variable baud tick gives 64 clocks per bit.
`timescale 1ns/1ps
module tb_second_serial_port;
    import serial_one_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic baud_tick = 1'b0;
    logic [1:0] bcnt = 2'h0;
    logic [7:0] rd_data;
    logic data_pin_out, data_pin_oe, clock_pin_out, irq, drive_line;
    wire logic data_pin_in;
    int n_mismatch = 0;
    int total_checks = 0;
    row_t rows [0:7] = '{'{8'ha8, 8'h5a, 8'h5a}, '{8'h87, 8'hff, 8'hc0}, '{8'h87, 8'h00, 8'h00},
        '{8'hc0, 8'h28, 8'h28}, '{8'hc0, 8'h03, 8'h03}, '{8'hc0, 8'h00, 8'h00},
        '{8'h55, 8'hff, 8'h00}, '{8'ha8, 8'h00, 8'h00}};

    // The shared data pin: the port wins while it drives, else the partner's pull-up line.
    assign data_pin_in = data_pin_oe ? data_pin_out : drive_line;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        bcnt <= bcnt + 2'h1;
        baud_tick <= (bcnt == 2'h3);
    end

    serial_one_port i_serial_one_port (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .baud_tick(baud_tick),
        .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
        .clock_pin_out(clock_pin_out), .irq(irq));
    serial_partner i_serial_partner (.clk(clk), .line_in(clock_pin_out),
        .shift_data(data_pin_out), .shift_oe(data_pin_oe), .drive_line(drive_line));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk_byte(rd_data, exp);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        logic [7:0] d;
        logic nine, stop, ok;
        int per;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].e);
        end
        wr(8'ha8, 8'hc0);
        wr(8'hc0, 8'h03);
        @(posedge clk);
        #1 chk_bit(irq, 1'b1);
        // A second reset in mid-run must bring pins and registers back to rest.
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1 chk_byte({4'h0, irq, clock_pin_out, data_pin_out, data_pin_oe}, 8'h06);
        @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'ha8, 8'h00);
        rd_chk(8'hc0, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(8'h87, k ? 8'h80 : 8'h00);
            wr(8'hc0, k ? 8'h80 : 8'h88);
            wr(8'ha8, 8'hc0);
            wr(8'hc1, k ? 8'h5a : 8'ha5);
            i_serial_partner.recv_frame(k ? 32 : 64, 1'b1, d, nine, stop, ok);
            rd_chk(8'hc0, k ? 8'h82 : 8'h8a);
            chk_byte(d, k ? 8'h5a : 8'ha5);
            chk_bit(nine, k ? 1'b0 : 1'b1);
            chk_bit(stop & ok, 1'b1);
            chk_bit(irq, 1'b1);
            repeat (64) @(posedge clk);
        end
        wr(8'ha8, 8'h40);
        @(posedge clk);
        #1 chk_bit(irq, 1'b0);
        wr(8'ha8, 8'h80);
        @(posedge clk);
        #1 chk_bit(irq, 1'b0);
        wr(8'ha8, 8'hc0);
        wr(8'hc0, 8'h00);
        @(posedge clk);
        #1 chk_bit(irq, 1'b0);
        for (int k = 0; k < 2; k++) begin
            wr(8'hc0, k ? 8'h00 : 8'h20);
            wr(8'hc1, 8'h3c ^ 8'(k));
            i_serial_partner.recv_shift(d, per, ok);
            chk_byte(d, 8'h3c ^ 8'(k));
            chk_byte(8'(per), k ? 8'h0c : 8'h04);
            chk_bit(ok, 1'b1);
            repeat (16) @(posedge clk);
            rd_chk(8'hc0, k ? 8'h02 : 8'h22);
        end
        wr(8'hc0, 8'h10);
        i_serial_partner.send_shift(8'hc5, ok);
        chk_bit(ok, 1'b1);
        rd_chk(8'hc0, 8'h11);
        rd_chk(8'hc1, 8'hc5);
        wr(8'hc0, 8'h70);
        wr(8'h87, 8'h40);
        i_serial_partner.send_frame(8'h81, 1'b0, 1'b0, 1'b0, 64);
        rd_chk(8'hc0, 8'hf0);
        rd_chk(8'hc1, 8'h00);
        rd_chk(8'hc0, 8'hf0);
        wr(8'hc0, 8'h50);
        rd_chk(8'hc0, 8'h50);
        wr(8'h87, 8'h00);
        i_serial_partner.send_frame(8'h96, 1'b0, 1'b0, 1'b1, 64);
        i_serial_partner.send_frame(8'h3c, 1'b0, 1'b0, 1'b1, 64);
        i_serial_partner.send_frame(8'he7, 1'b0, 1'b0, 1'b1, 64);
        rd_chk(8'hc0, 8'h55);
        rd_chk(8'hc1, 8'h96);
        rd_chk(8'hc1, 8'h3c);
        rd_chk(8'hc1, 8'he7);
        rd_chk(8'hc1, 8'h00);
        wr(8'hc1, 8'h69);
        i_serial_partner.recv_frame(64, 1'b0, d, nine, stop, ok);
        chk_byte(d, 8'h69);
        chk_bit(stop & ok, 1'b1);
        rd_chk(8'hc0, 8'h57);
        wr(8'hc0, 8'hf0);
        i_serial_partner.send_frame(8'h11, 1'b0, 1'b1, 1'b1, 64);
        rd_chk(8'hc0, 8'hf0);
        rd_chk(8'hc1, 8'h00);
        i_serial_partner.send_frame(8'h22, 1'b1, 1'b1, 1'b1, 64);
        rd_chk(8'hc0, 8'hf5);
        rd_chk(8'hc1, 8'h22);
        wr(8'hc0, 8'hc0);
        i_serial_partner.send_frame(8'h33, 1'b1, 1'b1, 1'b1, 64);
        rd_chk(8'hc0, 8'hc0);
        rd_chk(8'hc1, 8'h00);
        wrap_up();
    end
endmodule // tb_second_serial_port
